// >>> logic/i2csf_pkg.sv
// package for the serial bus stop and transfer flag block
// assumes a 32-bit apb slave on one clock
`default_nettype none
package i2csf_pkg;
    // ********************
    // register map
    // ********************
    localparam logic [7:0] status_off = 8'h00;
    localparam logic [7:0] control_off = 8'h04;
    localparam logic [7:0] irq_status_off = 8'h08;
    localparam logic [7:0] irq_mask_off = 8'h0c;

    // ********************
    // status field positions
    // ********************
    localparam int error_stop_bit = 7;
    localparam int normal_stop_bit = 6;
    localparam int transfer_request_bit = 5;
    localparam int second_address_bit = 4;
    localparam int general_irq_bit = 0;

    // ********************
    // control field positions and resets
    // ********************
    localparam int enable_bit = 0;
    localparam int mode_lsb = 1;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [2:0] control_reset = 3'h0;
    localparam logic [2:0] irq_mask_reset = 3'h0;

    // ********************
    // interrupt event positions
    // ********************
    localparam int ev_stop = 0;
    localparam int ev_transfer = 1;
    localparam int ev_error_stop = 2;

    typedef enum logic [1:0] {
        i2csf_slave,
        i2csf_master,
        i2csf_clocked
    } i2csf_mode_t;

    // events from the serial bus engine
    typedef struct packed {
        logic stop_after_frame;
        logic stop_in_frame;
        logic tx_empty_set;
        logic rx_full_set;
        logic second_address_match;
        logic general_irq_clear;
    } i2csf_events_t;
endpackage
`default_nettype wire

// >>> logic/i2csf_apb.sv
// apb slave front end for the flag block
// assumes a 32-bit apb master on the same clock
`timescale 1ns/1ps
`default_nettype none
module i2csf_apb (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // decoded access
    output logic acc_write,
    output logic acc_read,
    output logic [7:0] acc_addr,
    output logic [31:0] acc_wdata
);
    // one access pulse per transfer; slave always ready in the access phase
    always_comb begin
        acc_write = psel & penable & pwrite;
        acc_read = psel & penable & ~pwrite;
        acc_addr = paddr;
        acc_wdata = pwdata;
    end
endmodule // i2csf_apb
`default_nettype wire

// >>> logic/i2csf_flags.sv
// stop and continuous transfer status flags with apb access
// assumes bus engine events are one-cycle pulses on ref_clk
// Operation
// - normal stop flag is only meaningful in bus-format slave mode
// - stop after a completed frame sets the normal stop flag
// - writing 0 after reading 1 clears the normal stop flag
// - clearing the general interrupt flag clears the normal stop flag
// - transfer request flag marks each finished frame in continuous transfer
// - frame completion event drives the data transfer controller request; the code does so only while the interface is enabled
// - setting transfer request also sets the general interrupt flag
// - slave mode: buffer flag event sets request when second address matched
// - master or clocked mode: buffer flag event sets request
// - writing 0 after reading 1 clears the transfer request flag
// - general flag clear with interface enabled clears transfer request
// - error stop and normal stop are never both set
// - normal stop at bit 6, reset 0, read or clear only
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module i2csf_flags (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus engine
    input wire i2csf_pkg::i2csf_events_t events,
    // system
    output logic dtc_request,
    output logic general_irq,
    output logic irq
);
    // ********************
    // state
    // ********************
    typedef struct packed {
        logic error_stop_flag;
        logic normal_stop_flag;
        logic continuous_transfer_request_flag;
        logic general_interface_interrupt_flag;
        logic second_address_match_flag;
        logic seen_error_stop;
        logic seen_normal_stop;
        logic seen_request;
        logic seen_general;
        logic [2:0] control;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic dtc_request;
        logic irq;
    } i2csf_state_t;

    i2csf_state_t st;
    i2csf_state_t next_st;
    logic acc_write;
    logic acc_read;
    logic [7:0] acc_addr;
    logic [31:0] acc_wdata;

    i2csf_apb u_apb (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .acc_write(acc_write),
        .acc_read(acc_read),
        .acc_addr(acc_addr),
        .acc_wdata(acc_wdata)
    );

    // clears a flag written 0 only if it was read as 1 before
    function automatic logic cleared(input logic flag, input logic seen, input logic wbit);
        cleared = flag & seen & ~wbit;
    endfunction

    function automatic logic [7:0] status_byte(input i2csf_state_t s);
        status_byte = i2csf_pkg::status_reset;
        status_byte[i2csf_pkg::error_stop_bit] = s.error_stop_flag;
        status_byte[i2csf_pkg::normal_stop_bit] = s.normal_stop_flag;
        status_byte[i2csf_pkg::transfer_request_bit] = s.continuous_transfer_request_flag;
        status_byte[i2csf_pkg::second_address_bit] = s.second_address_match_flag;
        status_byte[i2csf_pkg::general_irq_bit] = s.general_interface_interrupt_flag;
    endfunction

    // ********************
    // next state
    // ********************
    logic status_wr;
    logic ctrl_wr;
    logic mask_wr;
    logic status_rd;
    logic irq_rd;
    logic slave_mode;
    logic enable;
    logic buffer_event;
    logic set_request;
    logic set_stop;
    logic set_error_stop;
    logic clr_general;
    logic [2:0] ev;

    always_comb begin
        next_st = st;
        status_wr = acc_write && acc_addr == i2csf_pkg::status_off;
        ctrl_wr = acc_write && acc_addr == i2csf_pkg::control_off;
        mask_wr = acc_write && acc_addr == i2csf_pkg::irq_mask_off;
        status_rd = acc_read && acc_addr == i2csf_pkg::status_off;
        irq_rd = acc_read && acc_addr == i2csf_pkg::irq_status_off;
        enable = st.control[i2csf_pkg::enable_bit];
        slave_mode = st.control[i2csf_pkg::mode_lsb +: 2] == 2'(i2csf_pkg::i2csf_slave);
        buffer_event = events.tx_empty_set | events.rx_full_set;
        // slave needs the second address match, master or clocked does not
        set_request = buffer_event
            & (slave_mode ? (st.second_address_match_flag | events.second_address_match)
                          : 1'b1);
        set_stop = slave_mode & events.stop_after_frame;
        set_error_stop = slave_mode & events.stop_in_frame & ~set_stop;
        clr_general = events.general_irq_clear
            | (status_wr & cleared(st.general_interface_interrupt_flag, st.seen_general,
                                   acc_wdata[i2csf_pkg::general_irq_bit]));

        // read-then-write-0 tracking
        if (status_rd) begin
            next_st.seen_error_stop = st.error_stop_flag;
            next_st.seen_normal_stop = st.normal_stop_flag;
            next_st.seen_request = st.continuous_transfer_request_flag;
            next_st.seen_general = st.general_interface_interrupt_flag;
        end

        if (status_wr) begin
            if (cleared(st.normal_stop_flag, st.seen_normal_stop,
                        acc_wdata[i2csf_pkg::normal_stop_bit]))
                next_st.normal_stop_flag = 1'b0;
            if (cleared(st.continuous_transfer_request_flag, st.seen_request,
                        acc_wdata[i2csf_pkg::transfer_request_bit]))
                next_st.continuous_transfer_request_flag = 1'b0;
            if (cleared(st.error_stop_flag, st.seen_error_stop,
                        acc_wdata[i2csf_pkg::error_stop_bit]))
                next_st.error_stop_flag = 1'b0;
        end
        if (clr_general) begin
            next_st.general_interface_interrupt_flag = 1'b0;
            next_st.normal_stop_flag = 1'b0;
            next_st.error_stop_flag = 1'b0;
            if (enable)
                next_st.continuous_transfer_request_flag = 1'b0;
        end
        if (status_wr || clr_general) begin
            next_st.seen_error_stop = 1'b0;
            next_st.seen_normal_stop = 1'b0;
            next_st.seen_request = 1'b0;
            next_st.seen_general = 1'b0;
        end

        // second address match is tracked here for the status view and for the slave mode request gate
        if (!slave_mode)
            next_st.second_address_match_flag = 1'b0;
        else if (events.second_address_match)
            next_st.second_address_match_flag = 1'b1;

        // hardware sets win over clears
        if (set_request) begin
            next_st.continuous_transfer_request_flag = 1'b1;
            next_st.general_interface_interrupt_flag = 1'b1;
        end
        if (set_stop) begin
            next_st.normal_stop_flag = 1'b1;
            next_st.error_stop_flag = 1'b0;
        end else if (set_error_stop) begin
            next_st.error_stop_flag = 1'b1;
            next_st.normal_stop_flag = 1'b0;
        end
        if (set_stop || set_error_stop)
            next_st.general_interface_interrupt_flag = 1'b1;

        if (ctrl_wr)
            next_st.control = acc_wdata[2:0];
        if (mask_wr)
            next_st.irq_mask = acc_wdata[2:0];

        // sticky events, cleared by reading, new event wins
        ev = 3'h0;
        ev[i2csf_pkg::ev_stop] = set_stop;
        ev[i2csf_pkg::ev_transfer] = set_request;
        ev[i2csf_pkg::ev_error_stop] = set_error_stop;
        next_st.irq_status = (irq_rd ? 3'h0 : st.irq_status) | ev;

        // apb answer, one cycle access phase
        next_st.pready = psel & ~penable;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0;
        if (psel && !penable) begin
            case (paddr)
                i2csf_pkg::status_off: next_st.prdata = {24'h0, status_byte(st)};
                i2csf_pkg::control_off: next_st.prdata = {29'h0, st.control};
                i2csf_pkg::irq_status_off: next_st.prdata = {29'h0, st.irq_status};
                i2csf_pkg::irq_mask_off: next_st.prdata = {29'h0, st.irq_mask};
                default: next_st.pslverr = 1'b1;
            endcase
        end

        next_st.dtc_request = set_request & enable;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.control <= i2csf_pkg::control_reset;
            st.irq_mask <= i2csf_pkg::irq_mask_reset;
        end else begin
            st <= next_st;
        end
    end

    // ********************
    // outputs
    // ********************
    always_comb begin
        prdata = st.prdata;
        pready = st.pready;
        pslverr = st.pslverr;
        dtc_request = st.dtc_request;
        general_irq = st.general_interface_interrupt_flag;
        irq = st.irq;
    end
endmodule // i2csf_flags
`default_nettype wire

// >>> sim/i2csf_engine_model.sv
// serial bus engine stand-in: one-cycle event pulses
// assumes fire is called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module i2csf_engine_model (
    // clock
    input wire logic ref_clk,
    // events toward the flag block
    output var i2csf_pkg::i2csf_events_t events
);
    initial events = '0;
    // pulse for one cycle, then one quiet cycle
    task automatic fire(input logic [5:0] e);
        events <= e;
        @(posedge ref_clk);
        events <= '0;
        @(posedge ref_clk);
    endtask
endmodule // i2csf_engine_model
`default_nettype wire

// >>> sim/i2csf_flags_assertions.sv
// port assertions for the flag block
// assumes one clock, rst async active high
`timescale 1ns/1ps
`default_nettype none
module i2csf_flags_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // engine and system
    input wire i2csf_pkg::i2csf_events_t events,
    input wire logic dtc_request,
    input wire logic general_irq,
    input wire logic irq
);
    logic cause;
    assign cause = (|events[5:2]) || (psel && penable && pwrite);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_dtc_cause;
        dtc_request |-> $past(events.tx_empty_set || events.rx_full_set);
    endproperty
    a_dtc_cause: assert property (p_dtc_cause) else $error("dtc without event");
    property p_dtc_general;
        dtc_request |-> general_irq;
    endproperty
    a_dtc_general: assert property (p_dtc_general) else $error("request without flag");
    property p_gen_clear;
        events == 6'h01 |=> !general_irq;
    endproperty
    a_gen_clear: assert property (p_gen_clear) else $error("flag not cleared");
    property p_no_both;
        pready && !pwrite && paddr == i2csf_pkg::status_off |-> !(prdata[7] && prdata[6]);
    endproperty
    a_no_both: assert property (p_no_both) else $error("both stop flags set");
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_slverr;
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h0c);
    endproperty
    a_slverr: assert property (p_slverr) else $error("bad error response");
    property p_irq_rise;
        $rose(irq) |-> $past(cause) || $past(cause, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    property p_reset_quiet;
        $fell(rst) |-> !general_irq && !dtc_request && !irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output set at reset");
endmodule // i2csf_flags_assertions
bind i2csf_flags i2csf_flags_assertions chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .dtc_request(dtc_request),
    .general_irq(general_irq), .irq(irq));
`default_nettype wire

// >>> sim/tb_i2csf_flags.sv
// self-checking bench for the flag block over apb
// assumes the engine model drives the events
`timescale 1ns/1ps
`default_nettype none
module tb_i2csf_flags;
    logic ref_clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dtc_request;
    logic general_irq;
    logic irq;
    logic [31:0] rd;
    logic err;
    i2csf_pkg::i2csf_events_t events;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int dtc_seen = 0;
    always #4 ref_clk = ~ref_clk;
    i2csf_flags dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .dtc_request(dtc_request),
        .general_irq(general_irq), .irq(irq));
    i2csf_engine_model eng (.ref_clk(ref_clk), .events(events));
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (dtc_request === 1'b1) dtc_seen++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdm(input string what, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd & m, exp);
    endtask
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) rdm("reset", 8'(i * 4), '1, 32'h0);
        apb(1'b1, 8'h00, 32'hff);
        rdm("ones", 8'h00, '1, 32'h0);
        rdm("unmapped", 8'h10, '1, 32'h0);
        check("slverr", err, 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h0c, 32'h3);
        eng.fire(6'h08);
        rdm("no match", 8'h00, 32'h21, 32'h0);
        eng.fire(6'h02);
        eng.fire(6'h08);
        eng.fire(6'h20);
        rdm("match", 8'h00, 32'h61, 32'h61);
        check("irq", irq, 32'h1);
        check("general out", general_irq, 32'h1);
        rdm("irq status", 8'h08, '1, 32'h3);
        repeat (2) @(posedge ref_clk);
        check("irq off", irq, 32'h0);
        apb(1'b1, 8'h00, 32'h21);
        apb(1'b1, 8'h00, 32'h00);
        rdm("write clear", 8'h00, 32'h61, 32'h21);
        apb(1'b1, 8'h00, 32'h00);
        rdm("read clear", 8'h00, 32'h21, 32'h0);
        eng.fire(6'h02);
        eng.fire(6'h08);
        eng.fire(6'h20);
        eng.fire(6'h10);
        rdm("err stop", 8'h00, 32'he1, 32'ha1);
        eng.fire(6'h01);
        rdm("gen clear", 8'h00, 32'h61, 32'h0);
        check("general off", general_irq, 32'h0);
        apb(1'b1, 8'h04, 32'h3);
        eng.fire(6'h04);
        eng.fire(6'h20);
        rdm("master", 8'h00, 32'h61, 32'h21);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h04, 32'h5);
        eng.fire(6'h08);
        rdm("clocked", 8'h00, 32'h21, 32'h21);
        check("masked", irq, 32'h0);
        rdm("raw", 8'h08, 32'h2, 32'h2);
        rdm("raw clear", 8'h08, '1, 32'h0);
        apb(1'b1, 8'h04, 32'h4);
        eng.fire(6'h01);
        rdm("disabled clear", 8'h00, 32'h21, 32'h20);
        check("dtc count", dtc_seen, 32'd4);
        final_report();
    end
endmodule // tb_i2csf_flags
`default_nettype wire
